// *** dv/lcc_link_ctl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcc_link_ctl_asserts (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Register port and events
  input wire [7:0] regAddr,
  input wire regRdEn,
  input wire [15:0] regRdData,
  input wire regWrEn,
  input wire crcTestDone,
  input wire protoErr,
  input wire bothCtlAsserted,
  input wire fwdIsocPkt,
  // Link outputs
  input wire syncFloodOn,
  input wire [3:0] crcCheckLanes,
  input wire [3:0] txCrcBadLanes,
  input wire crcTestRun,
  input wire txIdleMode,
  input wire txHoldStatic,
  input wire txTristate,
  input wire txClkRun,
  input wire txDrop,
  input wire rxIgnore,
  input wire ctlHoldDone,
  input wire fwdUseIsocSet,
  input wire [2:0] rxWidthApplied,
  input wire [2:0] txWidthApplied
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ****
  // Lanes per width code; reserved codes use none
  // ****
  function automatic [3:0] laneMask(input [2:0] c);
    case (c)
      3'h0, 3'h4, 3'h5: laneMask = 4'h1;
      3'h1: laneMask = 4'h3;
      3'h3: laneMask = 4'hf;
      default: laneMask = 4'h0;
    endcase
  endfunction
  a_second_link_hard: assert property (
    $past(regRdEn) && $past(regAddr) == 8'h08 |-> regRdData == 16'h00d0)
    else $error("second control not hardwired");
  // Width changes reach the lane masks on the same edge as the applied width
  a_check_lanes: assert property (
    $past(rxWidthApplied) == rxWidthApplied &&
    $past(rxWidthApplied, 2) == rxWidthApplied |->
    (crcCheckLanes & ~laneMask(rxWidthApplied)) == 4'h0)
    else $error("crc checked on unused lane");
  a_force_lanes: assert property (
    $past(txWidthApplied) == txWidthApplied &&
    $past(txWidthApplied, 2) == txWidthApplied |->
    (txCrcBadLanes & ~laneMask(txWidthApplied)) == 4'h0)
    else $error("bad crc on unused lane");
  a_test_done_clr: assert property (
    crcTestDone && !regWrEn |-> ##2 !crcTestRun)
    else $error("crc test not cleared");
  a_flood_origin: assert property (
    protoErr && !txDrop |-> ##[1:2] syncFloodOn)
    else $error("no flood on error");
  a_chain_drop: assert property (
    txDrop |-> crcCheckLanes == 4'h0 && rxIgnore)
    else $error("chain end still receiving");
  a_idle_needs_eoc: assert property (
    txIdleMode |-> txDrop)
    else $error("idle packets without chain end");
  a_tristate_noclk: assert property (
    txTristate |-> !txClkRun && !txHoldStatic)
    else $error("clock runs while floated");
  a_ctl_hold_min: assert property (
    $rose(ctlHoldDone) |-> $past(bothCtlAsserted, 16))
    else $error("control hold too short");
  a_iso_fwd_off: assert property (
    !fwdIsocPkt |=> !fwdUseIsocSet)
    else $error("isoc set without isoc packet");
endmodule
`default_nettype wire

// *** dv/lcc_link_ctl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcc_regs.vh"
module lcc_link_ctl_tb;
  logic core_clk, reset_n, regWrEn, regRdEn, rdLag;
  logic bothCtl, fwdIsoc, run, stopReq, unused, ovf;
  logic [7:0] regAddr, evt;
  logic [15:0] regWrData, r;
  logic [15:0] expQ[$];
  int errorCnt, checksDone;
  wire [15:0] rdData;
  wire lkClk, lane0, stopN, floodOn, testRun, idle, holdSt, triOn;
  wire clkRun, drop, ign, ctlDone, isoEn, useIso;
  wire [3:0] chkLanes, badLanes;
  wire [2:0] rxW, txW;
  wire [7:0] lk = {floodOn, testRun, idle, holdSt, triOn, clkRun, drop, ign};
  lcc_link_ctl #(.RX_WIDTH_MAX(`LCC_W16), .TX_WIDTH_MAX(`LCC_W4),
    .CRC_TEST_IMPL(1)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(rdData), .chainWarmReset(evt[0]), .rxCrcErrLane(evt[7:4]),
    .protoErr(evt[3]), .overflowErr(ovf), .linkInitDone(evt[1]),
    .crcTestDone(evt[2]), .bothCtlAsserted(bothCtl), .fwdIsocPkt(fwdIsoc),
    .linkClkPin(lkClk), .cadLane0Pin(lane0), .linkStopPin_n(stopN),
    .syncFloodOn(floodOn), .crcCheckLanes(chkLanes), .txCrcBadLanes(badLanes),
    .crcTestRun(testRun), .txIdleMode(idle), .txHoldStatic(holdSt),
    .txTristate(triOn), .txClkRun(clkRun), .txDrop(drop), .rxIgnore(ign),
    .ctlHoldDone(ctlDone), .isocFcPktEn(isoEn), .fwdUseIsocSet(useIso),
    .rxWidthApplied(rxW), .txWidthApplied(txW));
  lcc_peer peer (.run(run), .stopReq(stopReq), .unusedLink(unused),
    .linkClkPin(lkClk), .cadLane0Pin(lane0), .linkStopPin_n(stopN));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ****
  // Bus, compare and event tasks
  // ****
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input [7:0] a, input [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    wt(1);
    regWrEn <= 1'b0;
    wt(1);
  endtask
  task automatic rd(input [7:0] a, input [15:0] e);
    expQ.push_back(e);
    regAddr <= a;
    regRdEn <= 1'b1;
    wt(1);
    regRdEn <= 1'b0;
    wt(1);
  endtask
  task automatic cmpRd(input [15:0] got, input [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmpOut(input [7:0] got, input [7:0] exp);
    cmpRd({8'h00, got}, {8'h00, exp});
  endtask
  // Event pulses: [0] warm, [1] init, [2] test done, [3] proto, [7:4] crc
  task automatic pulse(input [7:0] m);
    evt <= m;
    wt(1);
    evt <= 8'h00;
    wt(4);
  endtask
  task automatic hold(input int lo, input int hi);
    stopReq <= 1'b1;
    wt(4);
    stopReq <= 1'b0;
    wt(8);
    bothCtl <= 1'b1;
    run <= 1'b1;
    wt(lo);
    cmpOut({7'h0, ctlDone}, 8'h00);
    wt(hi - lo);
    cmpOut({7'h0, ctlDone}, 8'h01);
    bothCtl <= 1'b0;
    run <= 1'b0;
  endtask
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (rdLag) cmpRd(rdData, expQ.pop_front());
    rdLag <= regRdEn;
  end
  initial begin
    wt(8000);
    errorCnt++;
    endOfTest();
  end
  // ****
  // Tests
  // ****
  initial begin
    {reset_n, regWrEn, regRdEn, bothCtl, fwdIsoc, ovf} = 6'h0;
    {run, stopReq, unused, regAddr, evt, regWrData} = '0;
    void'($urandom(66));
    wt(20);
    reset_n <= 1'b1;
    wt(2);
    rd(8'h04, 16'h0000);
    rd(8'h06, 16'h5151);
    rd(8'h08, 16'h00d0);
    rd(8'h0a, 16'h0000);
    rd(8'h20, 16'h0000);
    wr(8'h08, 16'hffff);
    rd(8'h08, 16'h00d0);
    $display("test registers done");
    r = $urandom;
    pulse({r[3:0] | 4'h1, 4'h0});
    rd(8'h04, {6'h0, r[1], 1'b1, 8'h00});
    wr(8'h04, 16'h0300);
    rd(8'h04, 16'h0000);
    wr(8'h04, 16'h000a);
    // Lane masks launch on the edge the write task returns at
    wt(1);
    cmpOut({chkLanes, badLanes}, 8'h31);
    pulse(8'h40);
    rd(8'h04, 16'h000a);
    pulse(8'h20);
    rd(8'h04, 16'h021a);
    cmpOut(lk, 8'h84);
    pulse(8'h08);
    wr(8'h04, 16'h031a);
    rd(8'h04, 16'h000a);
    ovf <= 1'b1;
    wt(1);
    ovf <= 1'b0;
    wt(2);
    rd(8'h04, 16'h001a);
    wr(8'h04, 16'h001a);
    $display("test crc done");
    pulse(8'h02);
    rd(8'h04, 16'h002a);
    wr(8'h04, 16'h000e);
    wt(3);
    cmpOut(lk, 8'hc4);
    pulse(8'h04);
    rd(8'h04, 16'h002a);
    wr(8'h04, 16'h004a);
    wt(3);
    cmpOut(lk, 8'ha7);
    wr(8'h04, 16'h000a);
    rd(8'h04, 16'h006a);
    wr(8'h04, 16'h008a);
    wt(3);
    cmpOut(lk, 8'h93);
    rd(8'h04, 16'h00ea);
    pulse(8'h01);
    rd(8'h04, 16'h0002);
    cmpOut(lk, 8'h04);
    $display("test chain done");
    wr(8'h04, 16'h1002);
    wt(3);
    cmpOut({6'h0, isoEn, useIso}, 8'h00);
    pulse(8'h01);
    fwdIsoc <= 1'b1;
    wt(3);
    cmpOut({6'h0, isoEn, useIso}, 8'h03);
    fwdIsoc <= 1'b0;
    $display("test isoc done");
    wr(8'h06, 16'h5051);
    rd(8'h06, 16'h5051);
    cmpOut({5'h0, rxW}, 8'h01);
    wr(8'h04, 16'h3002);
    stopReq <= 1'b1;
    wt(6);
    cmpOut(lk, 8'h09);
    wr(8'h04, 16'h1002);
    wt(3);
    cmpOut(lk, 8'h15);
    // 32 link edges for a 4-bit transmitter, 4 core cycles each
    hold(110, 150);
    cmpOut({5'h0, rxW}, 8'h00);
    cmpOut({5'h0, txW}, 8'h05);
    wr(8'h04, 16'h5002);
    hold(1200, 1280);
    $display("test stop done");
    unused <= 1'b1;
    wt(4);
    pulse(8'h01);
    rd(8'h04, 16'h5052);
    $display("test unused done");
    endOfTest();
  end
endmodule
bind lcc_link_ctl lcc_link_ctl_asserts chk (
  .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
  .regRdEn(regRdEn), .regRdData(regRdData), .regWrEn(regWrEn),
  .crcTestDone(crcTestDone), .protoErr(protoErr),
  .bothCtlAsserted(bothCtlAsserted), .fwdIsocPkt(fwdIsocPkt),
  .syncFloodOn(syncFloodOn), .crcCheckLanes(crcCheckLanes),
  .txCrcBadLanes(txCrcBadLanes), .crcTestRun(crcTestRun),
  .txIdleMode(txIdleMode), .txHoldStatic(txHoldStatic),
  .txTristate(txTristate), .txClkRun(txClkRun), .txDrop(txDrop),
  .rxIgnore(rxIgnore), .ctlHoldDone(ctlHoldDone),
  .fwdUseIsocSet(fwdUseIsocSet), .rxWidthApplied(rxWidthApplied),
  .txWidthApplied(txWidthApplied));
`default_nettype wire

// *** dv/lcc_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcc_peer (
  // Bench control
  input wire logic run,
  input wire logic stopReq,
  input wire logic unusedLink,
  // Pins toward the block
  output logic linkClkPin,
  output logic cadLane0Pin,
  output logic linkStopPin_n
);
  // Odd start offset keeps link clock unrelated to core clock
  initial begin
    linkClkPin = 1'b0;
    #7;
    forever #160 if (run) linkClkPin = ~linkClkPin;
  end
  // Unused interface ties lane 0 low
  assign cadLane0Pin = ~unusedLink;
  assign linkStopPin_n = ~stopReq;
endmodule
`default_nettype wire

// *** hw/lcc_link_ctl.v ***
`timescale 1ns/1ps
`default_nettype none
`include "lcc_regs.vh"
module lcc_link_ctl #(
  parameter [2:0] RX_WIDTH_MAX = `LCC_W8,
  parameter [2:0] TX_WIDTH_MAX = `LCC_W8,
  parameter CRC_TEST_IMPL = 1
) (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Register port
  input wire [`LCC_ADDR_W-1:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [15:0] regRdData,
  // Chain reset and link events, core clock domain
  input wire chainWarmReset,
  input wire [3:0] rxCrcErrLane,
  input wire protoErr,
  input wire overflowErr,
  input wire linkInitDone,
  input wire crcTestDone,
  input wire bothCtlAsserted,
  input wire fwdIsocPkt,
  // Pins from the link
  input wire linkClkPin,
  input wire cadLane0Pin,
  input wire linkStopPin_n,
  // Link control outputs
  output reg syncFloodOn,
  output reg [3:0] crcCheckLanes,
  output reg [3:0] txCrcBadLanes,
  output reg crcTestRun,
  output reg txIdleMode,
  output reg txHoldStatic,
  output reg txTristate,
  output reg txClkRun,
  output reg txDrop,
  output reg rxIgnore,
  output reg ctlHoldDone,
  output reg isocFcPktEn,
  output reg fwdUseIsocSet,
  output reg [2:0] rxWidthApplied,
  output reg [2:0] txWidthApplied
);
  // ****************************************
  // Helpers
  // ****************************************
  function [3:0] laneMask;
    input [2:0] code;
    begin
      case (code)
        `LCC_W8: laneMask = 4'h1;
        `LCC_W16: laneMask = 4'h3;
        `LCC_W32: laneMask = 4'hf;
        `LCC_W2: laneMask = 4'h1;
        `LCC_W4: laneMask = 4'h1;
        default: laneMask = 4'h0;
      endcase
    end
  endfunction

  function [6:0] holdBitTimes;
    input [2:0] code;
    integer bitTimes;
    begin
      case (code)
        `LCC_W2: bitTimes = `LCC_HOLD_BT_2;
        `LCC_W4: bitTimes = `LCC_HOLD_BT_4;
        default: bitTimes = `LCC_HOLD_BT_WIDE;
      endcase
      holdBitTimes = bitTimes[6:0];
    end
  endfunction

  localparam integer EXT_CTL_INT = `LCC_EXT_CTL_CYC;
  localparam [10:0] EXT_CTL_CYC = EXT_CTL_INT[10:0];

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [2:0] pinSync;

  lcc_sync #(.WIDTH(3)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .asyncIn({~linkStopPin_n, cadLane0Pin, linkClkPin}),
    .syncOut(pinSync)
  );

  wire linkClkS = pinSync[0];
  wire cad0S = pinSync[1];
  // Stop travels inverted: synchroniser reset level must mean not stopped
  wire stopS_n = ~pinSync[2];

  // ****************************************
  // State
  // ****************************************
  reg floodEn_r, testStart_r, forceErr_r, fail_r, initDone_r;
  reg chainEnd_r, txOff_r, isoc_flow_enable_r, isocEff_r, stopTri_r, extended_ctl_hold_r;
  reg [3:0] crcErr_r;
  reg [2:0] rxWidth_r, txWidth_r, rxWidthEff_r, txWidthEff_r;
  reg floodCond_r, linkClkPrev_r, stopPrev_r, afterStop_r;
  reg [1:0] relCnt_r;
  reg [10:0] holdCnt_r;

  wire wrCtrl = regWrEn && (regAddr == `LCC_OFF_CTRL_FIRST);
  wire wrCfg = regWrEn && (regAddr == `LCC_OFF_CFG_FIRST);
  wire linkEdge = linkClkS ^ linkClkPrev_r;
  wire stopRelease = stopS_n && !stopPrev_r;
  wire stopActive = !stopS_n;
  // Pins need two cycles through the synchroniser after release
  wire evalUnused = (relCnt_r == 2'h2);
  wire unusedLink = evalUnused && !cad0S;
  wire [3:0] rxLanes = laneMask(RX_WIDTH_MAX) & laneMask(rxWidthEff_r);
  wire [3:0] crcVisible = crcErr_r & rxLanes;
  wire [3:0] crcSet = rxCrcErrLane & rxLanes & {4{!chainEnd_r}};
  wire floodCond = floodEn_r && (|crcVisible);
  // Flood origination only; forwarded sync packets never reach here
  wire floodStart = !chainEnd_r &&
    ((floodCond && !floodCond_r) || protoErr || overflowErr);

  // ****************************************
  // Cold-reset fields
  // ****************************************
  always @(posedge core_clk) begin
    if (!reset_n) begin
      floodEn_r <= 1'b0;
      fail_r <= 1'b0;
      crcErr_r <= 4'h0;
      isoc_flow_enable_r <= 1'b0;
      stopTri_r <= 1'b0;
      extended_ctl_hold_r <= 1'b0;
      rxWidth_r <= RX_WIDTH_MAX;
      txWidth_r <= TX_WIDTH_MAX;
      floodCond_r <= 1'b0;
    end else begin
      floodCond_r <= floodCond;
      if (wrCtrl) begin
        floodEn_r <= regWrData[`LCC_B_FLOOD_EN];
        isoc_flow_enable_r <= regWrData[`LCC_B_ISOC_EN];
        stopTri_r <= regWrData[`LCC_B_STOP_TRI];
        extended_ctl_hold_r <= regWrData[`LCC_B_EXT_CTL];
      end
      if (wrCfg) begin
        rxWidth_r <= regWrData[`LCC_B_RXUSE_HI:`LCC_B_RXUSE_LO];
        txWidth_r <= regWrData[`LCC_B_TXUSE_HI:`LCC_B_TXUSE_LO];
      end
      // Set wins over a write-one clear
      if (floodStart || unusedLink) begin
        fail_r <= 1'b1;
      end else if (wrCtrl && regWrData[`LCC_B_FAIL]) begin
        fail_r <= 1'b0;
      end
      crcErr_r <= crcSet |
        (crcErr_r & ~({4{wrCtrl}} &
        regWrData[`LCC_B_CRC_HI:`LCC_B_CRC_LO]));
    end
  end

  // ****************************************
  // Warm chain reset fields
  // ****************************************
  always @(posedge core_clk) begin
    if (!reset_n || chainWarmReset) begin
      testStart_r <= 1'b0;
      forceErr_r <= 1'b0;
      initDone_r <= 1'b0;
      chainEnd_r <= 1'b0;
      txOff_r <= 1'b0;
      syncFloodOn <= 1'b0;
      relCnt_r <= 2'h0;
    end else begin
      if (relCnt_r != 2'h3) begin
        relCnt_r <= relCnt_r + 2'h1;
      end
      if (wrCtrl) begin
        forceErr_r <= regWrData[`LCC_B_FORCE_ERR];
      end
      if (wrCtrl && CRC_TEST_IMPL != 0) begin
        testStart_r <= regWrData[`LCC_B_TEST_START];
      end else if (crcTestDone) begin
        testStart_r <= 1'b0;
      end
      if (linkInitDone) begin
        initDone_r <= 1'b1;
      end
      if (unusedLink || (wrCtrl && regWrData[`LCC_B_CHAIN_END])) begin
        chainEnd_r <= 1'b1;
      end
      if (wrCtrl && regWrData[`LCC_B_TX_OFF]) begin
        txOff_r <= 1'b1;
      end
      if (floodStart) begin
        syncFloodOn <= 1'b1;
      end
    end
  end

  // ****************************************
  // Deferred configuration
  // ****************************************
  always @(posedge core_clk) begin
    if (!reset_n) begin
      rxWidthEff_r <= RX_WIDTH_MAX;
      txWidthEff_r <= TX_WIDTH_MAX;
      isocEff_r <= 1'b0;
      stopPrev_r <= 1'b1;
    end else begin
      stopPrev_r <= stopS_n;
      if (chainWarmReset || stopRelease) begin
        rxWidthEff_r <= rxWidth_r;
        txWidthEff_r <= txWidth_r;
      end
      if (chainWarmReset) begin
        isocEff_r <= isoc_flow_enable_r;
      end
    end
  end

  // ****************************************
  // Control line hold after stop
  // ****************************************
  always @(posedge core_clk) begin
    if (!reset_n) begin
      linkClkPrev_r <= 1'b0;
      afterStop_r <= 1'b0;
      holdCnt_r <= 11'h000;
      ctlHoldDone <= 1'b0;
    end else begin
      linkClkPrev_r <= linkClkS;
      if (stopActive) begin
        afterStop_r <= 1'b1;
      end else if (linkInitDone) begin
        afterStop_r <= 1'b0;
      end
      if (!bothCtlAsserted || stopActive) begin
        holdCnt_r <= 11'h000;
        ctlHoldDone <= 1'b0;
      end else if (afterStop_r && extended_ctl_hold_r) begin
        // Extended hold counts core cycles: DLL lock time, not bits
        if (holdCnt_r >= EXT_CTL_CYC - 11'h001) begin
          ctlHoldDone <= 1'b1;
        end else begin
          holdCnt_r <= holdCnt_r + 11'h001;
        end
      end else if (linkEdge) begin
        // Each link clock edge is one bit-time on a double-rate link
        if (holdCnt_r >= {4'h0, holdBitTimes(txWidthEff_r)} - 11'h001) begin
          ctlHoldDone <= 1'b1;
        end else begin
          holdCnt_r <= holdCnt_r + 11'h001;
        end
      end
    end
  end

  // ****************************************
  // Link-facing outputs
  // ****************************************
  always @(posedge core_clk) begin
    if (!reset_n) begin
      crcCheckLanes <= 4'h0;
      txCrcBadLanes <= 4'h0;
      crcTestRun <= 1'b0;
      txIdleMode <= 1'b0;
      txHoldStatic <= 1'b0;
      txTristate <= 1'b0;
      txClkRun <= 1'b0;
      txDrop <= 1'b0;
      rxIgnore <= 1'b0;
      isocFcPktEn <= 1'b0;
      fwdUseIsocSet <= 1'b0;
      rxWidthApplied <= RX_WIDTH_MAX;
      txWidthApplied <= TX_WIDTH_MAX;
    end else begin
      crcCheckLanes <= rxLanes & {4{!chainEnd_r}};
      txCrcBadLanes <= {4{forceErr_r}} &
        laneMask(TX_WIDTH_MAX) & laneMask(txWidthEff_r);
      crcTestRun <= testStart_r;
      txIdleMode <= chainEnd_r && !txOff_r;
      txHoldStatic <= txOff_r || (stopActive && !stopTri_r);
      txTristate <= stopActive && stopTri_r && !txOff_r;
      txClkRun <= !txOff_r && !(stopActive && stopTri_r);
      txDrop <= chainEnd_r;
      rxIgnore <= chainEnd_r || stopActive;
      isocFcPktEn <= isocEff_r;
      fwdUseIsocSet <= fwdIsocPkt && isocEff_r;
      rxWidthApplied <= rxWidthEff_r;
      txWidthApplied <= txWidthEff_r;
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  reg [15:0] rdMux;

  always @* begin
    rdMux = 16'h0000;
    if (regAddr == `LCC_OFF_CTRL_FIRST) begin
      rdMux[`LCC_B_FLOOD_EN] = floodEn_r;
      rdMux[`LCC_B_TEST_START] = testStart_r;
      rdMux[`LCC_B_FORCE_ERR] = forceErr_r;
      rdMux[`LCC_B_FAIL] = fail_r;
      rdMux[`LCC_B_INIT_DONE] = initDone_r;
      rdMux[`LCC_B_CHAIN_END] = chainEnd_r;
      rdMux[`LCC_B_TX_OFF] = txOff_r;
      rdMux[`LCC_B_CRC_HI:`LCC_B_CRC_LO] = crcVisible;
      rdMux[`LCC_B_ISOC_EN] = isoc_flow_enable_r;
      rdMux[`LCC_B_STOP_TRI] = stopTri_r;
      rdMux[`LCC_B_EXT_CTL] = extended_ctl_hold_r;
    end else if (regAddr == `LCC_OFF_CFG_FIRST) begin
      rdMux[`LCC_B_RXMAX_HI:`LCC_B_RXMAX_LO] = RX_WIDTH_MAX;
      rdMux[`LCC_B_TXMAX_HI:`LCC_B_TXMAX_LO] = TX_WIDTH_MAX;
      rdMux[`LCC_B_RXUSE_HI:`LCC_B_RXUSE_LO] = rxWidth_r;
      rdMux[`LCC_B_TXUSE_HI:`LCC_B_TXUSE_LO] = txWidth_r;
    end else if (regAddr == `LCC_OFF_CTRL_SECOND) begin
      rdMux = `LCC_CTRL_SECOND_HARD;
    end else begin
      rdMux = 16'h0000;
    end
  end

  // Data only in the cycle after the strobe, zero otherwise
  always @(posedge core_clk) begin
    if (!reset_n) begin
      regRdData <= 16'h0000;
    end else if (regRdEn) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// *** hw/lcc_regs.vh ***
`ifndef LCC_REGS_VH
`define LCC_REGS_VH
// ****************************************
// Register offsets
// ****************************************
`define LCC_ADDR_W 8
`define LCC_OFF_CTRL_FIRST 8'h04
`define LCC_OFF_CFG_FIRST 8'h06
`define LCC_OFF_CTRL_SECOND 8'h08
`define LCC_OFF_CFG_SECOND 8'h0a
// ****************************************
// Control register fields
// ****************************************
`define LCC_B_FLOOD_EN 1
`define LCC_B_TEST_START 2
`define LCC_B_FORCE_ERR 3
`define LCC_B_FAIL 4
`define LCC_B_INIT_DONE 5
`define LCC_B_CHAIN_END 6
`define LCC_B_TX_OFF 7
`define LCC_B_CRC_LO 8
`define LCC_B_CRC_HI 11
`define LCC_B_ISOC_EN 12
`define LCC_B_STOP_TRI 13
`define LCC_B_EXT_CTL 14
// Absent second link: failure, chain end, transmitter off read one
`define LCC_CTRL_SECOND_HARD 16'h00d0
// ****************************************
// Configuration register fields
// ****************************************
`define LCC_B_RXMAX_LO 0
`define LCC_B_RXMAX_HI 2
`define LCC_B_TXMAX_LO 4
`define LCC_B_TXMAX_HI 6
`define LCC_B_RXUSE_LO 8
`define LCC_B_RXUSE_HI 10
`define LCC_B_TXUSE_LO 12
`define LCC_B_TXUSE_HI 14
// Width codes
`define LCC_W8 3'h0
`define LCC_W16 3'h1
`define LCC_W32 3'h3
`define LCC_W2 3'h4
`define LCC_W4 3'h5
`define LCC_WNC 3'h7
// ****************************************
// Timing
// ****************************************
`define LCC_CLK_NS 40
`define LCC_EXT_CTL_NS 50000
`define LCC_EXT_CTL_CYC ((`LCC_EXT_CTL_NS + `LCC_CLK_NS - 1) / `LCC_CLK_NS)
`define LCC_HOLD_BT_WIDE 16
`define LCC_HOLD_BT_4 32
`define LCC_HOLD_BT_2 64
`endif

// *** hw/lcc_sync.v ***
`timescale 1ns/1ps
`default_nettype none
module lcc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Data
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] stable_r;

  always @(posedge core_clk) begin
    if (!reset_n) begin
      meta_r <= {WIDTH{1'b0}};
      stable_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= asyncIn;
      stable_r <= meta_r;
    end
  end

  assign syncOut = stable_r;
endmodule
`default_nettype wire
